// *** core/mdv_consts.svh ***
/*
  Constants of the multiply/divide unit: register word indices, status
  field positions, reset values and calculation lengths.
  Assumes a 5-bit Avalon-MM byte address whose bits 4:2 select a word.
*/
`ifndef MDV_CONSTS_SVH
`define MDV_CONSTS_SVH

// ----------------------------------------------------------------
// Register word indices (byte address = index * 4)
// ----------------------------------------------------------------
`define MDV_IDX_B0 3'h0
`define MDV_IDX_B1 3'h1
`define MDV_IDX_B2 3'h2
`define MDV_IDX_B3 3'h3
`define MDV_IDX_B4 3'h4
`define MDV_IDX_B5 3'h5
`define MDV_IDX_STAT 3'h6
`define MDV_IDX_NONE 3'h7

// ----------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------
`define MDV_ST_ERR 7
`define MDV_ST_OVF 6
`define MDV_FLAG_RST 1'b0
`define MDV_WAIT_RST 1'b1

// ----------------------------------------------------------------
// Calculation lengths in system clock periods (one period = one MCLK)
// ----------------------------------------------------------------
`define MDV_CYC_DIV32 5'h11
`define MDV_CYC_DIV16 5'h09
`define MDV_CYC_MUL 5'h0B

`endif

// *** core/mdv_pkg.sv ***
/*
  Types of the multiply/divide unit: operation and sequence encodings,
  the bus request carrier and the packed state of the top module.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mdv_pkg;

  // Operation remembered from the last accepted write order
  typedef enum logic [1:0] {OP_NONE, OP_DIV32, OP_DIV16, OP_MUL} mdv_op_t;

  // Progress through the operand write orders
  typedef enum logic [3:0] {
    WS_IDLE, WS_0, WS_01, WS_012, WS_0123, WS_01234, WS_014, WS_04, WS_041
  } mdv_wseq_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } mdv_req_t;

  // Whole state of the top module
  typedef struct packed {
    logic [5:0][7:0] bytes;
    mdv_wseq_t wseq;
    mdv_op_t op;
    logic busy;
    logic [4:0] cnt;
    logic [2:0] rstep;
    logic rd_done;
    logic err;
    logic ovf;
    logic wait_n;
    logic [31:0] rdata;
  } mdv_state_t;

endpackage

// *** core/mdv_unit.sv ***
/*
  Multiply/divide unit: six byte-wide operand/result registers and a
  status register behind an Avalon-MM slave with waitrequest.
  Assumes the master holds each request until it sees waitrequest low.
*/
// Functional notes
// - Unsigned 16x16 multiply, 32/16 divide and 16/16 divide.
// - Calculation starts only on byte 5 write ending a valid order.
// - Unrelated accesses between operand writes do not break the order.
// - Order 0,1,2,3,4,5 selects 32/16 divide.
// - Order 0,1,4,5 selects 16/16 divide.
// - Order 0,4,1,5 selects 16x16 multiply.
// - Lengths: 17 periods for 32/16, 9 for 16/16, 11 for multiply.
// - Error flag bit 7 sets on operand access during calculation.
// - Status read after completion clears a set error flag.
// - Overflow bit 6: product above FFFF or divisor zero.
// - Overflow flag is replaced at every completion.
// - Status bits 5 to 0 read as zero.
// - 32/16 results read as bytes 0 to 5 in order.
// - 16/16 results read as bytes 0,1,4,5 in order.
// - Product read as bytes 0 to 3 in order.
// - Unrelated accesses between result reads do not break read-out.
`timescale 1ns/100ps
`include "mdv_consts.svh"

module mdv_unit
  import mdv_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Avalon-MM slave
  input wire mdv_req_t AVS_REQ,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Unit state
  output logic BUSY,
  output logic READOUT_DONE
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Register index expected at a given step of the result read-out
  function automatic logic [2:0] exp_idx(input mdv_op_t op, input logic [2:0] step);
    logic [2:0] r;
    r = `MDV_IDX_NONE;
    unique case (op)
      OP_DIV32: r = (step < 3'h6) ? step : `MDV_IDX_NONE;
      OP_DIV16: r = (step < 3'h2) ? step : (step < 3'h4) ? step + 3'h2 : `MDV_IDX_NONE;
      OP_MUL: r = (step < 3'h4) ? step : `MDV_IDX_NONE;
      OP_NONE: r = `MDV_IDX_NONE;
    endcase
    return r;
  endfunction

  // Number of result bytes of an operation
  function automatic logic [2:0] rd_len(input mdv_op_t op);
    logic [2:0] r;
    r = 3'h0;
    unique case (op)
      OP_DIV32: r = 3'h6;
      OP_DIV16: r = 3'h4;
      OP_MUL: r = 3'h4;
      OP_NONE: r = 3'h0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  mdv_state_t q;
  mdv_state_t n;

  logic [2:0] idx;
  logic mapped;
  logic is_opnd;
  logic req;
  logic commit;
  logic wr_ok;
  logic rd_ok;
  logic done;
  logic [31:0] dvd;
  logic [15:0] dvs;
  logic [31:0] prod;
  logic [31:0] quo;
  logic [15:0] rem;

  // Word decode; unaligned or out-of-range addresses are unmapped
  assign idx = AVS_REQ.address[4:2];
  assign mapped = (AVS_REQ.address[1:0] == 2'h0) && (idx <= `MDV_IDX_STAT);
  assign is_opnd = mapped && (idx <= `MDV_IDX_B5);
  assign req = AVS_REQ.read | AVS_REQ.write;
  // Access takes effect at the edge where waitrequest is seen low
  assign commit = req && !q.wait_n;
  assign wr_ok = commit && AVS_REQ.write && AVS_REQ.byteenable[0] && is_opnd;
  assign rd_ok = commit && AVS_REQ.read && is_opnd;
  assign done = q.busy && (q.cnt == 5'h01);

  // ----------------------------------------------------------------
  // Arithmetic, evaluated on the held operands at completion
  // ----------------------------------------------------------------
  // One divider serves both divide widths; 16/16 zero-extends
  assign dvd = (q.op == OP_DIV32) ? {q.bytes[3], q.bytes[2], q.bytes[1], q.bytes[0]}
                                  : {16'h0000, q.bytes[1], q.bytes[0]};
  assign dvs = {q.bytes[5], q.bytes[4]};
  assign prod = {q.bytes[1], q.bytes[0]} * dvs;
  // Zero divisor: quotient all ones, remainder is dividend low half
  assign quo = (dvs == 16'h0000) ? 32'hFFFFFFFF : dvd / {16'h0000, dvs};
  always_comb begin
    logic [31:0] r32;
    r32 = 32'h00000000;
    if (dvs != 16'h0000) begin
      r32 = dvd % {16'h0000, dvs};
    end
    rem = (dvs == 16'h0000) ? dvd[15:0] : r32[15:0];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    // Waitrequest drops for exactly one cycle per request
    if (req && q.wait_n) begin
      n.wait_n = 1'b0;
      n.rdata = 32'h00000000;
      if (AVS_REQ.read && is_opnd) begin
        n.rdata = {24'h000000, q.bytes[idx]};
      end else if (AVS_REQ.read && idx == `MDV_IDX_STAT && mapped) begin
        n.rdata[`MDV_ST_ERR] = q.err;
        n.rdata[`MDV_ST_OVF] = q.ovf; // bits 5..0 stay zero
      end
    end else begin
      n.wait_n = 1'b1;
    end

    // Status read clears the error flag once calculation is over
    if (commit && AVS_REQ.read && mapped && idx == `MDV_IDX_STAT && !q.busy) begin
      n.err = 1'b0;
    end
    // Operand write during calculation is refused, any operand access is flagged; set wins
    if (q.busy && (wr_ok || rd_ok)) begin
      n.err = 1'b1;
    end

    // Operand writes and the order tracker; unrelated accesses leave it
    if (wr_ok && !q.busy) begin
      n.bytes[idx] = AVS_REQ.writedata[7:0];
      n.wseq = WS_IDLE; // departure abandons the order
      if (idx == `MDV_IDX_B0) begin
        n.wseq = WS_0; // restart at byte 0
        n.rstep = 3'h0;
        n.rd_done = 1'b0;
      end else begin
        unique case (q.wseq)
          WS_0: begin
            if (idx == `MDV_IDX_B1) n.wseq = WS_01;
            if (idx == `MDV_IDX_B4) n.wseq = WS_04;
          end
          WS_01: begin
            if (idx == `MDV_IDX_B2) n.wseq = WS_012;
            if (idx == `MDV_IDX_B4) n.wseq = WS_014;
          end
          WS_012: if (idx == `MDV_IDX_B3) n.wseq = WS_0123;
          WS_0123: if (idx == `MDV_IDX_B4) n.wseq = WS_01234;
          WS_04: if (idx == `MDV_IDX_B1) n.wseq = WS_041;
          WS_01234, WS_014, WS_041: begin
            // Only a byte 5 write here ends an order and starts work
            if (idx == `MDV_IDX_B5) begin
              n.busy = 1'b1;
              if (q.wseq == WS_01234) begin
                n.op = OP_DIV32;
                n.cnt = `MDV_CYC_DIV32;
              end else if (q.wseq == WS_014) begin
                n.op = OP_DIV16;
                n.cnt = `MDV_CYC_DIV16;
              end else begin
                n.op = OP_MUL;
                n.cnt = `MDV_CYC_MUL;
              end
            end
          end
          WS_IDLE: n.wseq = WS_IDLE;
        endcase
      end
    end

    // Calculation countdown; results land in the last period
    if (q.busy) begin
      n.cnt = q.cnt - 5'h01;
      if (done) begin
        n.busy = 1'b0;
        n.rstep = 3'h0;
        n.rd_done = 1'b0;
        if (q.op == OP_MUL) begin
          {n.bytes[3], n.bytes[2], n.bytes[1], n.bytes[0]} = prod;
          n.ovf = (prod[31:16] != 16'h0000);
        end else begin
          {n.bytes[3], n.bytes[2], n.bytes[1], n.bytes[0]} = quo;
          {n.bytes[5], n.bytes[4]} = rem;
          n.ovf = (dvs == 16'h0000);
        end
      end
    end

    // Read-out tracker advances only on the next expected byte
    if (rd_ok && !q.busy && !q.rd_done && idx == exp_idx(q.op, q.rstep)) begin
      n.rstep = q.rstep + 3'h1;
      if (q.rstep + 3'h1 == rd_len(q.op)) begin
        n.rd_done = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Operand bytes have no defined power-up value but are cleared here
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      q <= '0;
      q.wseq <= WS_IDLE;
      q.op <= OP_NONE;
      q.err <= `MDV_FLAG_RST;
      q.ovf <= `MDV_FLAG_RST;
      q.wait_n <= `MDV_WAIT_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign AVS_READDATA = q.rdata;
  assign AVS_WAITREQUEST = q.wait_n;
  assign BUSY = q.busy;
  assign READOUT_DONE = q.rd_done;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  div32_len_a: assert property ($rose(q.busy) && q.op == OP_DIV32 |->
    ##16 q.busy ##1 !q.busy) else $error("32/16 length wrong");
  div16_len_a: assert property ($rose(q.busy) && q.op == OP_DIV16 |->
    ##8 q.busy ##1 !q.busy) else $error("16/16 length wrong");
  mul_len_a: assert property ($rose(q.busy) && q.op == OP_MUL |->
    ##10 q.busy ##1 !q.busy) else $error("multiply length wrong");
  start_cause_a: assert property ($rose(q.busy) |->
    $past(wr_ok) && $past(idx) == `MDV_IDX_B5) else $error("start without byte 5");
  err_set_a: assert property (q.busy && (wr_ok || rd_ok) |=> q.err)
    else $error("error flag not set");
  err_clear_a: assert property (commit && AVS_REQ.read && idx == `MDV_IDX_STAT && mapped &&
    !q.busy |=> !q.err) else $error("error flag not cleared");
  mul_ovf_a: assert property ($fell(q.busy) && q.op == OP_MUL |->
    q.ovf == (q.bytes[3] != 8'h00 || q.bytes[2] != 8'h00))
    else $error("multiply overflow wrong");
  // Bytes 5,4 hold the remainder after a divide, so look at the divisor one cycle back
  div_ovf_a: assert property ($fell(q.busy) && q.op != OP_MUL |->
    q.ovf == ($past(dvs) == 16'h0000)) else $error("divide overflow wrong");
  stat_zero_a: assert property (!q.wait_n |-> q.rdata[5:0] == 6'h00 || $past(is_opnd))
    else $error("status low bits set");
  // The last period loads results, so a refused write there is judged elsewhere
  busy_hold_a: assert property (q.busy && !done && wr_ok |=> $stable(q.bytes))
    else $error("operand changed while busy");
  wait_pulse_a: assert property (req && q.wait_n |=> !q.wait_n ##1 q.wait_n)
    else $error("waitrequest not one cycle");

  // ----------------------------------------------------------------
  // Order and read-out tracking
  // ----------------------------------------------------------------

  // A byte 0 write outside a calculation reopens the order, whatever came before
  wseq_restart_a: assert property (wr_ok && !q.busy && idx == `MDV_IDX_B0 |=>
    q.wseq == WS_0) else $error("order not restarted");

  // A new order also rewinds the read-out tracker
  rd_rewind_a: assert property (wr_ok && !q.busy && idx == `MDV_IDX_B0 |=>
    q.rstep == 3'h0 && !q.rd_done) else $error("read tracker not rewound");

  // Byte 5 outside a complete order must not start anything
  bad_start_a: assert property (wr_ok && !q.busy && idx == `MDV_IDX_B5 &&
    !(q.wseq inside {WS_01234, WS_014, WS_041}) |=> !q.busy)
    else $error("start from broken order");

  // Reads and foreign accesses leave the write order alone
  wseq_keep_a: assert property (!(wr_ok && !q.busy) |=> $stable(q.wseq))
    else $error("order moved without write");

  // Only an expected read, a completion or a new order moves the read tracker
  rstep_keep_a: assert property (!rd_ok && !done && !wr_ok |=> $stable(q.rstep))
    else $error("read tracker moved");

  // Read-out completes only on an accepted operand read
  rd_done_cause_a: assert property ($rose(q.rd_done) |-> $past(rd_ok))
    else $error("read-out done without read");

  // ----------------------------------------------------------------
  // Calculation bookkeeping
  // ----------------------------------------------------------------

  // The countdown is loaded with one of the three documented lengths
  cnt_load_a: assert property ($rose(q.busy) |->
    q.cnt inside {`MDV_CYC_DIV32, `MDV_CYC_DIV16, `MDV_CYC_MUL})
    else $error("countdown load wrong");

  // Overflow only ever changes at a completion
  ovf_keep_a: assert property (!done |=> $stable(q.ovf))
    else $error("overflow moved between completions");

  // A product has no remainder, so bytes 5,4 are left as they were
  mul_keep_a: assert property ($fell(q.busy) && q.op == OP_MUL |->
    $stable({q.bytes[5], q.bytes[4]})) else $error("multiply touched bytes 5,4");

  // Read data is cleared for writes so stale bytes never leak out
  wr_rdata_a: assert property (req && q.wait_n && !AVS_REQ.read |=>
    q.rdata == 32'h00000000) else $error("read data not cleared");

  div32_c: cover property ($rose(q.busy) && q.op == OP_DIV32);
  mul_c: cover property ($rose(q.busy) && q.op == OP_MUL);
  div16_c: cover property ($rose(q.busy) && q.op == OP_DIV16);
  readout_c: cover property ($rose(q.rd_done) && q.op == OP_DIV16);
  err_c: cover property ($rose(q.err));

endmodule

// *** test/mdv_host.sv ***
/*
  Host core model: issues single Avalon-MM reads and writes to the unit.
  Assumes its tasks are called just after a rising MCLK edge.
*/
`timescale 1ns/100ps

module mdv_host
  import mdv_pkg::*;
(
  // Clock
  input wire logic MCLK,
  // Avalon-MM master side
  output mdv_req_t REQ,
  input wire logic [31:0] RDATA,
  input wire logic WAITREQ
);
  // Idle bus at time zero
  initial REQ = '0;

  // One bus cycle; only the bench watchdog ends a hung wait
  task automatic xfer(input logic wr, input logic [2:0] idx, input logic [7:0] d,
      output logic [7:0] q);
    REQ.read <= !wr;
    REQ.write <= wr;
    REQ.address <= {idx, 2'h0};
    REQ.writedata <= {24'h000000, d};
    REQ.byteenable <= 4'hF;
    @(posedge MCLK);
    while (WAITREQ !== 1'b0) begin
      @(posedge MCLK);
    end
    q = RDATA[7:0];
    REQ.read <= 1'b0;
    REQ.write <= 1'b0;
    // Let an edge pass so the next request never lands on this one
    @(posedge MCLK);
  endtask
endmodule

// *** test/tb.sv ***
/*
  Self-checking bench of the multiply/divide unit.
  Assumes the host model in mdv_host.sv and a 25 MHz clock.
*/
`timescale 1ns/100ps

module tb
  import mdv_pkg::*;
;
  typedef struct packed {
    logic [1:0] op;
    logic [31:0] a;
    logic [15:0] b;
    logic [31:0] q;
    logic [15:0] r;
    logic ovf;
  } mdv_row_t;

  logic mclk = 1'b0;
  logic rstn = 1'b0;
  mdv_req_t req;
  logic [31:0] rdata;
  logic waitreq;
  logic busy;
  logic done_o;
  logic [7:0] q;
  int mismatches = 0;
  int n_checks = 0;
  int busy_cnt = 0;

  // ----------------------------------------------------------------
  // Tables: ops 0 = 32/16 divide, 1 = 16/16 divide, 2 = multiply
  // ----------------------------------------------------------------
  mdv_row_t rows [6] = '{
    '{2'h0, 32'h12345678, 16'h0010, 32'h01234567, 16'h0008, 1'h0},
    '{2'h1, 32'h00001234, 16'h0034, 32'h00000059, 16'h0020, 1'h0},
    '{2'h1, 32'h0000FFFF, 16'hFFFF, 32'h00000001, 16'h0000, 1'h0},
    '{2'h2, 32'h00001234, 16'h0100, 32'h00123400, 16'h0000, 1'h1},
    '{2'h2, 32'h000000FF, 16'h0101, 32'h0000FFFF, 16'h0000, 1'h0},
    '{2'h0, 32'hCAFE1234, 16'h0000, 32'hFFFFFFFF, 16'h1234, 1'h1}};
  logic [2:0] w_ord [3][6] = '{'{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5},
    '{3'h0, 3'h1, 3'h4, 3'h5, 3'h0, 3'h0}, '{3'h0, 3'h4, 3'h1, 3'h5, 3'h0, 3'h0}};
  logic [2:0] r_ord [3][6] = '{'{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5},
    '{3'h0, 3'h1, 3'h4, 3'h5, 3'h0, 3'h0}, '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h0}};
  int n_acc [3] = '{6, 4, 4};
  int n_cyc [3] = '{17, 9, 11};

  mdv_unit dut (.MCLK(mclk), .RSTN(rstn), .AVS_REQ(req), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .BUSY(busy), .READOUT_DONE(done_o));
  mdv_host host (.MCLK(mclk), .REQ(req), .RDATA(rdata), .WAITREQ(waitreq));

  // Clock and calculation length counter
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] pick(logic [31:0] lo, logic [15:0] hi, logic [2:0] i);
    return (i < 3'h4) ? lo[8*i +: 8] : hi[8*(i-4) +: 8];
  endfunction

  // Operand writes low byte first, an unmapped read slipped in after the second
  task automatic start(input mdv_row_t r);
    logic [7:0] d;
    busy_cnt = 0;
    for (int k = 0; k < n_acc[r.op]; k++) begin
      host.xfer(1'b1, w_ord[r.op][k], pick(r.a, r.b, w_ord[r.op][k]), d);
      if (k == 1) host.xfer(1'b0, 3'h7, 8'h00, d);
    end
  endtask

  // Wait out the calculation, check status, then read results in order
  task automatic finish(input mdv_row_t r, input logic err);
    logic [7:0] d;
    int t;
    t = 0;
    while (busy === 1'b1 && t < 40) begin // host stays awake until done
      @(posedge mclk);
      t++;
    end
    chk(busy_cnt, n_cyc[r.op]);
    host.xfer(1'b0, 3'h6, 8'h00, d);
    chk(d, {err, r.ovf, 6'h00});
    for (int k = 0; k < n_acc[r.op]; k++) begin
      host.xfer(1'b0, r_ord[r.op][k], 8'h00, d);
      chk(d, pick(r.q, r.r, r_ord[r.op][k]));
      if (k == 1) host.xfer(1'b0, 3'h7, 8'h00, d);
    end
    chk(done_o, 1'b1);
  endtask

  task automatic results();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    host.xfer(1'b0, 3'h6, 8'h00, q);
    chk(q, 8'h00);
    // Table rows, every operation kind
    foreach (rows[i]) begin
      start(rows[i]);
      finish(rows[i], 1'b0);
    end
    // Operand accesses during a calculation set the error flag
    start(rows[0]);
    host.xfer(1'b1, 3'h0, 8'hAA, q);
    host.xfer(1'b0, 3'h6, 8'h00, q);
    finish(rows[0], 1'b1);
    host.xfer(1'b0, 3'h6, 8'h00, q);
    chk(q, 8'h00);
    // A broken order never starts; byte 0 then restarts tracking
    host.xfer(1'b1, 3'h0, 8'h11, q);
    host.xfer(1'b1, 3'h1, 8'h22, q);
    host.xfer(1'b1, 3'h4, 8'h33, q);
    host.xfer(1'b1, 3'h1, 8'h44, q);
    host.xfer(1'b1, 3'h5, 8'h55, q);
    repeat (2) @(posedge mclk);
    chk(busy, 1'b0);
    start(rows[4]);
    finish(rows[4], 1'b0);
    // Second reset in mid calculation
    start(rows[0]);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({busy, waitreq, done_o}, 3'h2);
    rstn <= 1'b1;
    @(posedge mclk);
    host.xfer(1'b0, 3'h6, 8'h00, q);
    chk(q, 8'h00);
    results();
  end
endmodule
